// *** rtl/ues_top.sv ***
// uart error status and control: apb registers, baud timer, serial rx/tx with error flags
// assumes a 25 MHz pclk and an asynchronous rxd pin
//
// Functional notes
// R1: in modes 1-3 a byte latched while previous unread sets rx overrun flag
// R2: a stop bit sampled low sets the framing error flag
// R3: control bit 6 shows overrun flag in status view, else mode_select_low
// R4: control bit 7 shows framing flag in status view, else mode_select_high
// R5: software sets doubler and timer1 clock select for standard reload values
// R6: with both set, bit rate outside mode 2 is pclk / (16 * (256 - reload)); mode 2 takes 16 ticks of 2 pclk
// R7: status view select in power control picks status or mode bits
// R8: writing serial buffer while transmitting sets tx collision flag on bit 5
// R9: error flags stay set until written 0 while status view is selected
`timescale 1ns/100ps
`default_nettype none
`include "ues_defs.svh"
module ues_top #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic rxd,
    output logic txd,
    // interrupt
    output logic irq
);
    import ues_pkg::*;

    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
        flag_upd = set | (cur & ~clr);
    endfunction

    localparam ues_state_t ST_RST = '{rx_st: UES_RX_IDLE, txd: 1'b1, default: '0};

    ues_state_t s;
    ues_state_t n;

    ////////////////////////////////////////////////////////////////////////////
    logic acc;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wb;
    logic mode_on;
    logic nine;
    logic t_tick;
    logic ovf;
    logic os_tick;
    logic rx_load;
    logic rx_fe;
    logic tx_end;
    logic tx_coll;
    logic [7:0] rx_data;
    logic rx_9th;
    logic [7:0] ctl_rd;
    logic sbuf_rd;
    logic ist_rd;
    logic ctl_wr;

    always_comb begin
        n = s;
        acc = psel & penable & s.pready;
        wr = acc & pwrite;
        addr = paddr[7:0];
        wb = pwdata[7:0];
        ctl_wr = wr & (addr == `UES_OFF_SERIAL_PORT_CONTROL);
        sbuf_rd = acc & ~pwrite & (addr == `UES_OFF_SERIAL_BUFFER);
        mode_on = s.mode_select_high | s.mode_select_low;
        nine = s.mode_select_high;
        rx_load = 1'b0;
        rx_fe = 1'b0;
        tx_end = 1'b0;
        tx_coll = 1'b0;
        rx_data = nine ? s.rx_shift[7:0] : s.rx_shift[8:1];
        rx_9th = s.rx_shift[8];
        // baud timer: overflow reloads, 16 overflows per bit with doubler
        t_tick = s.timer1_clock_select | (s.prescale == `UES_PRESCALE_LAST); // R6
        n.prescale = (s.timer1_clock_select | (s.prescale == `UES_PRESCALE_LAST)) ? 4'h0 :
            s.prescale + 4'h1;
        ovf = t_tick & (s.timer == 8'hff);
        if (t_tick) begin
            n.timer = ovf ? s.timer1_reload_value : s.timer + 8'h01; // R6
        end
        if (ovf) begin
            n.half = ~s.half;
        end
        if (s.mode_select_high & ~s.mode_select_low) begin
            os_tick = (s.mode2_div == (s.baud_doubler ? `UES_MODE2_DIV_FAST :
                `UES_MODE2_DIV_SLOW));
            n.mode2_div = os_tick ? 2'h0 : s.mode2_div + 2'h1;
        end else begin
            os_tick = ovf & (s.baud_doubler | s.half); // R6
            n.mode2_div = 2'h0;
        end
        ////////////////////////////////////////////////////////////////////////
        // receiver
        n.rx_sync1 = rxd;
        n.rx_sync2 = s.rx_sync1;
        case (s.rx_st)
            UES_RX_IDLE: begin
                if (~s.rx_sync2 & s.rx_enable & mode_on) begin
                    n.rx_st = UES_RX_START;
                    n.rx_os = 4'h0;
                end
            end
            UES_RX_START: begin
                if (os_tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == `UES_OS_MID) begin
                        n.rx_os = 4'h0;
                        n.rx_bit = 4'h0;
                        n.rx_st = s.rx_sync2 ? UES_RX_IDLE : UES_RX_DATA;
                    end
                end
            end
            UES_RX_DATA: begin
                if (os_tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == `UES_OS_LAST) begin
                        n.rx_shift = {s.rx_sync2, s.rx_shift[8:1]};
                        n.rx_bit = s.rx_bit + 4'h1;
                        if (s.rx_bit == (nine ? `UES_RX_BITS_9 : `UES_RX_BITS_8)) begin
                            n.rx_st = UES_RX_STOP;
                        end
                    end
                end
            end
            UES_RX_STOP: begin
                if (os_tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == `UES_OS_LAST) begin
                        n.rx_st = UES_RX_IDLE;
                        rx_fe = ~s.rx_sync2; // R2
                        rx_load = ~s.multiproc_enable | (nine ? rx_9th : s.rx_sync2);
                    end
                end
            end
            default: begin
                n.rx_st = UES_RX_IDLE;
            end
        endcase
        ////////////////////////////////////////////////////////////////////////
        // transmitter
        if (s.tx_busy & os_tick) begin
            n.tx_os = s.tx_os + 4'h1;
            if (s.tx_os == `UES_OS_LAST) begin
                if (s.tx_bit == 4'h0) begin
                    n.tx_busy = 1'b0;
                    tx_end = 1'b1;
                end else begin
                    n.txd = s.tx_shift[0];
                    n.tx_shift = {1'b1, s.tx_shift[9:1]};
                    n.tx_bit = s.tx_bit - 4'h1;
                end
            end
        end
        if (wr & (addr == `UES_OFF_SERIAL_BUFFER)) begin
            if (s.tx_busy) begin
                tx_coll = 1'b1; // R8
            end else if (mode_on) begin
                n.tx_busy = 1'b1;
                n.txd = 1'b0;
                n.tx_os = 4'h0;
                n.tx_shift = {1'b1, nine ? s.tx_ninth : 1'b1, wb};
                n.tx_bit = nine ? `UES_TX_BITS_9 : `UES_TX_BITS_8;
            end
        end
        ////////////////////////////////////////////////////////////////////////
        // control register writes, hardware sets win over software clears
        if (ctl_wr) begin
            if (s.status_view_select) begin // R7
                n.framing_error_flag = s.framing_error_flag & wb[7]; // R9
                n.rx_overrun_flag = s.rx_overrun_flag & wb[6]; // R9
                n.tx_collision_flag = s.tx_collision_flag & wb[5]; // R9
            end else begin
                n.mode_select_high = wb[7]; // R7
                n.mode_select_low = wb[6];
                n.multiproc_enable = wb[5];
            end
            n.rx_enable = wb[4];
            n.tx_ninth = wb[3];
            n.rx_ninth = wb[2];
            n.tx_done_flag = wb[1];
            n.rx_done_flag = wb[0];
        end
        if (sbuf_rd) begin
            n.rx_unread = 1'b0;
        end
        if (rx_load) begin
            n.rx_buffer = rx_data;
            n.rx_ninth = nine ? rx_9th : s.rx_sync2;
            n.rx_done_flag = 1'b1;
            n.rx_unread = 1'b1;
        end
        n.rx_overrun_flag = n.rx_overrun_flag | (rx_load & s.rx_unread); // R1
        n.framing_error_flag = n.framing_error_flag | rx_fe; // R2
        n.tx_collision_flag = n.tx_collision_flag | tx_coll; // R8
        n.tx_done_flag = n.tx_done_flag | tx_end;
        ////////////////////////////////////////////////////////////////////////
        // other registers
        if (wr & (addr == `UES_OFF_POWER_CONTROL)) begin
            n.status_view_select = wb[`UES_BIT_VIEW_SELECT]; // R7
            n.baud_doubler = wb[`UES_BIT_BAUD_DOUBLER]; // R5
            n.timer1_clock_select = wb[`UES_BIT_T1_CLOCK_SELECT]; // R5
        end
        if (wr & (addr == `UES_OFF_RELOAD)) begin
            n.timer1_reload_value = wb;
        end
        if (wr & (addr == `UES_OFF_INT_MASK)) begin
            n.int_mask = wb[4:0];
        end
        ist_rd = wr & (addr == `UES_OFF_INT_STATUS);
        n.int_status[0] = flag_upd(s.int_status[0], rx_load, ist_rd & wb[0]);
        n.int_status[1] = flag_upd(s.int_status[1], tx_end, ist_rd & wb[1]);
        n.int_status[2] = flag_upd(s.int_status[2], rx_load & s.rx_unread, ist_rd & wb[2]);
        n.int_status[3] = flag_upd(s.int_status[3], rx_fe, ist_rd & wb[3]);
        n.int_status[4] = flag_upd(s.int_status[4], tx_coll, ist_rd & wb[4]);
        n.irq = |(s.int_status & s.int_mask);
        ////////////////////////////////////////////////////////////////////////
        // apb answer: one wait state, read data captured before the final edge
        ctl_rd = {s.status_view_select ? s.framing_error_flag : s.mode_select_high, // R4
            s.status_view_select ? s.rx_overrun_flag : s.mode_select_low, // R3
            s.status_view_select ? s.tx_collision_flag : s.multiproc_enable, // R8
            s.rx_enable, s.tx_ninth, s.rx_ninth, s.tx_done_flag, s.rx_done_flag};
        n.pready = psel & penable & ~s.pready;
        n.pslverr = 1'b0;
        n.prdata = 32'h0000_0000;
        if (psel & penable & ~s.pready) begin
            case (addr)
                `UES_OFF_SERIAL_PORT_CONTROL: n.prdata = {24'h00_0000, ctl_rd};
                `UES_OFF_POWER_CONTROL: n.prdata = {29'h0000_0000, s.timer1_clock_select,
                    s.baud_doubler, s.status_view_select};
                `UES_OFF_RELOAD: n.prdata = {24'h00_0000, s.timer1_reload_value};
                `UES_OFF_SERIAL_BUFFER: n.prdata = {24'h00_0000, s.rx_buffer};
                `UES_OFF_INT_STATUS: n.prdata = {27'h000_0000, s.int_status};
                `UES_OFF_INT_MASK: n.prdata = {27'h000_0000, s.int_mask};
                default: n.pslverr = 1'b1;
            endcase
            if (paddr != ADDR_W'(addr)) begin
                n.pslverr = 1'b1;
                n.prdata = 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign txd = s.txd;
    assign irq = s.irq;
endmodule // ues_top
`default_nettype wire

// *** rtl/ues_defs.svh ***
// register offsets, field positions, reset values and counts of the uart status block
// assumes an 8-bit apb byte address decoded against these offsets
`ifndef UES_DEFS_SVH
`define UES_DEFS_SVH
`define UES_OFF_SERIAL_PORT_CONTROL 8'h98
`define UES_OFF_POWER_CONTROL 8'h9c
`define UES_OFF_RELOAD 8'ha0
`define UES_OFF_SERIAL_BUFFER 8'ha4
`define UES_OFF_INT_STATUS 8'ha8
`define UES_OFF_INT_MASK 8'hac
`define UES_BIT_VIEW_SELECT 0
`define UES_BIT_BAUD_DOUBLER 1
`define UES_BIT_T1_CLOCK_SELECT 2
`define UES_RST_CONTROL 8'h00
`define UES_RST_RELOAD 8'h00
`define UES_PRESCALE_LAST 4'hb
`define UES_OS_MID 4'h7
`define UES_OS_LAST 4'hf
`define UES_MODE2_DIV_FAST 2'h1
`define UES_MODE2_DIV_SLOW 2'h3
`define UES_TX_BITS_8 4'h9
`define UES_TX_BITS_9 4'ha
`define UES_RX_BITS_8 4'h7
`define UES_RX_BITS_9 4'h8
`endif

// *** rtl/ues_pkg.sv ***
// types of the uart status block
// assumes nothing beyond a systemverilog tool
`default_nettype none
package ues_pkg;
    typedef enum logic [3:0] {
        UES_RX_IDLE = 4'b0001,
        UES_RX_START = 4'b0010,
        UES_RX_DATA = 4'b0100,
        UES_RX_STOP = 4'b1000
    } ues_rx_state_t;

    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic multiproc_enable;
        logic rx_enable;
        logic tx_ninth;
        logic rx_ninth;
        logic tx_done_flag;
        logic rx_done_flag;
        logic framing_error_flag;
        logic rx_overrun_flag;
        logic tx_collision_flag;
        logic status_view_select;
        logic baud_doubler;
        logic timer1_clock_select;
        logic [7:0] timer1_reload_value;
        logic [7:0] timer;
        logic [3:0] prescale;
        logic half;
        logic [1:0] mode2_div;
        ues_rx_state_t rx_st;
        logic rx_sync1;
        logic rx_sync2;
        logic [3:0] rx_os;
        logic [3:0] rx_bit;
        logic [8:0] rx_shift;
        logic [7:0] rx_buffer;
        logic rx_unread;
        logic tx_busy;
        logic [9:0] tx_shift;
        logic [3:0] tx_os;
        logic [3:0] tx_bit;
        logic txd;
        logic [4:0] int_status;
        logic [4:0] int_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ues_state_t;
endpackage
`default_nettype wire

// *** testbench/ues_props.sv ***
// port assertions of the uart status block
// assumes binding to ues_top and offsets from ues_defs.svh
`timescale 1ns/100ps
`default_nettype none
`include "ues_defs.svh"
module ues_props #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial and interrupt
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_mask_off;
        pready && pwrite && paddr == `UES_OFF_INT_MASK && pwdata[4:0] == 5'h0;
    endsequence
    AST_ANSWER: assert property (s_access |=> pready)
        else $error("no answer in second access cycle");
    AST_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_UNMAPPED: assert property (pready && !(paddr inside {`UES_OFF_SERIAL_PORT_CONTROL,
        `UES_OFF_POWER_CONTROL, `UES_OFF_RELOAD, `UES_OFF_SERIAL_BUFFER, `UES_OFF_INT_STATUS,
        `UES_OFF_INT_MASK}) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (pready && paddr == `UES_OFF_SERIAL_PORT_CONTROL |-> !pslverr)
        else $error("control access refused");
    AST_MASK_OFF: assert property (s_mask_off |=> ##1 !irq)
        else $error("irq with all sources masked");
    AST_START_BIT: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
endmodule // ues_props
`default_nettype wire

// *** testbench/ues_remote.sv ***
// remote serial partner: sends frames on rxd, captures frames from txd
// assumes 8-bit frames, lsb first, BIT_CLKS pclk cycles per bit
`timescale 1ns/100ps
`default_nettype none
module ues_remote #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input wire logic pclk,
    // serial line
    input wire logic txd,
    output logic rxd,
    // capture
    output logic [8:0] got,
    output int got_n
);
    initial begin
        rxd = 1'b1;
        got = 9'h000;
        got_n = 0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT_CLKS) @(posedge pclk);
        end
        rxd <= 1'b1;
        repeat (BIT_CLKS) @(posedge pclk);
    endtask
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge pclk);
            got[i] = txd;
        end
        got_n++;
    end
endmodule // ues_remote
`default_nettype wire

// *** testbench/test_ues_top.sv ***
// self-checking bench of the uart status block
// assumes ues_top, ues_remote and ues_props compiled first
`timescale 1ns/100ps
`default_nettype none
module test_ues_top;
    localparam logic [7:0] RELOAD = 8'hff;
    localparam int BITC = 16 * (256 - RELOAD);
    logic pclk, presetn, psel, penable, pwrite, rxd, txd, irq, pready, pslverr, serr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [8:0] got;
    int got_n, fail_count, check_count, cyc, n;
    ues_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    ues_remote #(.BIT_CLKS(BITC)) remote (.pclk(pclk), .txd(txd), .rxd(rxd), .got(got),
        .got_n(got_n));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rv & m, e);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {cyc, fail_count, check_count} = {32'h0, 32'h0, 32'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(8'h98, 32'hffffffff, 32'h0);
        chk(8'ha0, 32'hffffffff, 32'h0);
        chk(8'hb0, 32'hffffffff, 32'h0);
        check({31'h0, serr}, 32'h1);
        apb(1'b1, 8'h9c, 32'h06);
        apb(1'b1, 8'ha0, {24'h0, RELOAD});
        // timer must reach its first overflow before bit timing is steady
        repeat (300) @(posedge pclk);
        apb(1'b1, 8'h98, 32'h50);
        chk(8'h98, 32'hf0, 32'h50);
        apb(1'b1, 8'ha4, 32'h35);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            if (txd !== 1'b0) break;
            n++;
        end
        // the return edge of the write already saw the start bit
        check(n + 1, BITC);
        apb(1'b1, 8'ha4, 32'h99);
        repeat (2000) begin
            @(posedge pclk);
            if (got_n == 1) break;
        end
        repeat (2 * BITC) @(posedge pclk);
        check({23'h0, got}, 32'h135);
        remote.send(8'ha5, 1'b1);
        remote.send(8'h3c, 1'b1);
        chk(8'ha4, 32'hff, 32'h3c);
        remote.send(8'h0f, 1'b0);
        apb(1'b1, 8'h9c, 32'h07);
        chk(8'h98, 32'he0, 32'he0);
        apb(1'b1, 8'h98, 32'h70);
        chk(8'h98, 32'he0, 32'h60);
        apb(1'b1, 8'h98, 32'h10);
        chk(8'h98, 32'he0, 32'h0);
        apb(1'b1, 8'h9c, 32'h06);
        chk(8'h98, 32'he0, 32'h40);
        chk(8'ha8, 32'h1f, 32'h1f);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, 8'hac, 32'h04);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, 8'ha8, 32'h04);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        chk(8'ha8, 32'h1f, 32'h1b);
        // mode 2: 16 ticks of 2 pclk per bit, tick phase free by one cycle
        apb(1'b1, 8'h98, 32'h80);
        chk(8'h98, 32'he0, 32'h80);
        apb(1'b1, 8'ha4, 32'h55);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            if (txd !== 1'b0) break;
            n++;
        end
        check((n + 2) / 2, 16);
        apb(1'b1, 8'hac, 32'h1f);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, 8'hac, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        close_out();
    end
endmodule // test_ues_top
bind ues_top ues_props #(.ADDR_W(ADDR_W)) props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire
